// ---- charger_pkg.sv ----
// Shared constants, carrier types and register map of the charger control.
// Assumes a single 200 MHz core clock and a synchronous active-high reset.
package charger_pkg;

  // Core clock.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Millisecond prescaler derived from the clock rate.
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;

  // Battery detection windows, in milliseconds.
  localparam int unsigned DISCH_WINDOW_MS = 1000;
  localparam int unsigned LOWI_WINDOW_MS = 500;

  // Status blink rate in tenths of a hertz, and its half period in ms.
  localparam int unsigned BLINK_DHZ = 5;
  localparam int unsigned BLINK_HALF_MS = 10_000 / (2 * BLINK_DHZ);

  // Fast-charge safety timer.
  localparam int unsigned SAFETY_HOURS = 5;
  localparam int unsigned SAFETY_MS = SAFETY_HOURS * 3600 * 1000;

  // Switching period in core clocks; plain default.
  localparam int unsigned SW_PERIOD_CYCLES = 200;

  // Bootstrap refresh: low comparator must stay set longer than this.
  localparam int unsigned BOOT_LOW_CYCLES = 3;
  localparam int unsigned REFRESH_NS = 80;
  localparam int unsigned REFRESH_CYCLES = REFRESH_NS / CLK_PERIOD_NS;
  localparam int unsigned DEAD_NS = 30;
  localparam int unsigned DEAD_CYCLES =
    (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register map, byte addresses.
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
  localparam int unsigned CTRL_ALLOW_BIT = 0;
  localparam logic CTRL_ALLOW_RESET = 1'b1;

  // AHB transfer type and response.
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

  // Comparator results and the charge-permit pin, all asynchronous.
  typedef struct packed {
    logic charge_permit;
    logic undervoltage_lockout;
    logic input_overvoltage;
    logic sleep;
    logic above_recharge;
    logic below_low_battery;
    logic bootstrap_low;
    logic pwm_request;
    logic suspend;
    logic charge_done;
    logic other_ok;
  } sense_t;

  // Charge sequencing states; Gray codes along the usual path.
  typedef enum logic [2:0] {
    ST_OFF      = 3'b100,
    ST_DISCH    = 3'b000,
    ST_LOWI     = 3'b001,
    ST_CHARGE   = 3'b011,
    ST_DONE     = 3'b010,
    ST_FAULT_HI = 3'b110,
    ST_FAULT_LO = 3'b111
  } charge_state_t;

  // Read-only status word, low bits of the status register.
  typedef struct packed {
    logic refresh_active;
    logic pg_pin_level;
    logic stat_pin_level;
    logic supply_valid;
    logic battery_absent;
    logic timer_fault;
    logic charging;
    charge_state_t state;
  } status_t;

endpackage

// ---- sync2.sv ----
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherency is implied.
`timescale 1ns/100ps
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // Only the second stage is visible outside.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;

endmodule

// ---- charger_ctrl.sv ----
// Charger control: timer fault recovery, indicators, charge permit,
// battery detection sequence and bootstrap refresh of the gate drive.
// Assumes asynchronous comparator inputs and an AHB-Lite register master.
//
// Behaviour
// - Fault above recharge held until battery drops
// - Permit low or reset clears any fault
// - Fault below recharge enables trickle current
// - Rising above recharge drops trickle, recovers
// - Supply-valid indicator on when supply valid
// - Charge only with permit high, conditions met
// - Permit falling edge clears timers and faults
// - Undriven permit pin reads as low
// - Status indicator on, off or blinking
// - Detection runs only while permit high
// - Detection starts discharge sink, one-second window
// - Low battery in window: low current, 500ms
// - Above recharge in window: absent, restart
// - Window expiry means battery present, charge
// - Bootstrap low over three cycles: refresh
// - Full duty after refresh, refresh on recurrence
// - Near-full effective duty with upper kept on
// - Five-hour safety timer raises timer fault
// - Recharge drop, reset or toggle restarts cycle
`timescale 1ns/100ps
module charger_ctrl #(
  parameter int unsigned MS_CYCLES = charger_pkg::MS_CYCLES,
  parameter int unsigned DISCH_MS = charger_pkg::DISCH_WINDOW_MS,
  parameter int unsigned LOWI_MS = charger_pkg::LOWI_WINDOW_MS,
  parameter int unsigned BLINK_MS = charger_pkg::BLINK_HALF_MS,
  parameter int unsigned SAFETY_MS = charger_pkg::SAFETY_MS,
  parameter int unsigned SW_CYCLES = charger_pkg::SW_PERIOD_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Comparators and charge-permit pin.
  input wire charger_pkg::sense_t sense_i,
  // Power stage and current sources.
  output logic hs_gate_o,
  output logic ls_gate_o,
  output logic discharge_sink_o,
  output logic low_current_o,
  output logic fault_trickle_current_o,
  output logic charge_enable_o,
  // Open-drain indicators.
  input wire logic supply_valid_indicator_i,
  output logic supply_valid_indicator_o,
  output logic supply_valid_indicator_oe_o,
  input wire logic charge_state_indicator_i,
  output logic charge_state_indicator_o,
  output logic charge_state_indicator_oe_o
);

  localparam int unsigned MS_W = $clog2(MS_CYCLES + 1);
  localparam int unsigned WIN_W = $clog2(DISCH_MS + LOWI_MS + 1);
  localparam int unsigned BL_W = $clog2(BLINK_MS + 1);
  localparam int unsigned SAF_W = $clog2(SAFETY_MS + 1);
  localparam int unsigned SW_W = $clog2(SW_CYCLES + 1);
  localparam int unsigned RF_TOTAL =
    2 * charger_pkg::DEAD_CYCLES + charger_pkg::REFRESH_CYCLES;
  localparam int unsigned RF_W = $clog2(RF_TOTAL + 1);

  // True once a counter has reached the last count of its span.
  function automatic logic at_last(input logic [31:0] cnt,
                                   input int unsigned span);
    at_last = (cnt == (span - 1));
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisation.
  // ---------------------------------------------------------------
  charger_pkg::sense_t sns;
  logic [$bits(charger_pkg::sense_t)-1:0] sns_bits;
  logic [1:0] pin_bits;

  sync2 #(
    .WIDTH($bits(charger_pkg::sense_t))
  ) u_sense_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .d_i(sense_i),
    .q_o(sns_bits)
  );

  sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .d_i({supply_valid_indicator_i, charge_state_indicator_i}),
    .q_o(pin_bits)
  );

  assign sns = charger_pkg::sense_t'(sns_bits);

  // The synchroniser resets low, so an undriven permit counts as off.
  logic permit;
  logic permit_d_reg;
  logic permit_fall;

  assign permit = sns.charge_permit;
  assign permit_fall = permit_d_reg & ~permit;

  // Supply valid: not locked out, not over voltage, not asleep.
  logic supply_valid;
  assign supply_valid = ~sns.undervoltage_lockout &
                        ~sns.input_overvoltage & ~sns.sleep;

  // ---------------------------------------------------------------
  // Register file.
  // ---------------------------------------------------------------
  logic ctrl_allow_reg;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  charger_pkg::status_t status;

  logic addr_phase;
  logic [31:0] rd_word;

  assign addr_phase = hsel_i & hready_i &
                      (htrans_i == charger_pkg::HTRANS_NONSEQ);
  assign rd_word = (haddr_i == charger_pkg::CTRL_OFS) ?
                     {31'h0000_0000, ctrl_allow_reg} :
                   (haddr_i == charger_pkg::STATUS_OFS) ?
                     {{(32 - $bits(charger_pkg::status_t)){1'b0}}, status} :
                     32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_phase & hwrite_i;
      if (addr_phase) begin
        wr_addr_reg <= haddr_i;
      end
      if (addr_phase & ~hwrite_i) begin
        hrdata_reg <= rd_word;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_allow_reg <= charger_pkg::CTRL_ALLOW_RESET;
    end else if (wr_pend_reg && wr_addr_reg == charger_pkg::CTRL_OFS) begin
      ctrl_allow_reg <= hwdata_i[charger_pkg::CTRL_ALLOW_BIT];
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o = charger_pkg::HRESP_OKAY;

  // ---------------------------------------------------------------
  // Millisecond time base and blink phase.
  // ---------------------------------------------------------------
  logic [MS_W-1:0] ms_cnt_reg;
  logic ms_tick;
  logic [BL_W-1:0] blink_cnt_reg;
  logic blink_ph_reg;

  assign ms_tick = at_last(32'(ms_cnt_reg), MS_CYCLES);

  always_ff @(posedge core_clk_i) begin
    if (srst_i || permit_fall) begin
      ms_cnt_reg <= '0;
      blink_cnt_reg <= '0;
      blink_ph_reg <= 1'b0;
    end else begin
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
      if (ms_tick) begin
        if (at_last(32'(blink_cnt_reg), BLINK_MS)) begin
          blink_cnt_reg <= '0;
          blink_ph_reg <= ~blink_ph_reg;
        end else begin
          blink_cnt_reg <= blink_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Charge sequencing.
  // ---------------------------------------------------------------
  charger_pkg::charge_state_t state_reg;
  charger_pkg::charge_state_t state_next;
  logic [WIN_W-1:0] win_reg;
  logic [SAF_W-1:0] safety_reg;
  logic absent_reg;
  logic absent_next;
  logic safety_clr;
  logic charging;
  logic disch_done;
  logic lowi_done;
  logic safety_done;

  assign charging = (state_reg == charger_pkg::ST_CHARGE) & permit &
                    supply_valid & sns.other_ok & ~sns.suspend &
                    ctrl_allow_reg;
  assign disch_done = ms_tick & at_last(32'(win_reg), DISCH_MS);
  assign lowi_done = ms_tick & at_last(32'(win_reg), LOWI_MS);
  assign safety_done = ms_tick & charging &
                       at_last(32'(safety_reg), SAFETY_MS);
  assign safety_clr = (state_next == charger_pkg::ST_CHARGE) &&
                      (state_reg != charger_pkg::ST_CHARGE);

  always_comb begin
    state_next = state_reg;
    absent_next = absent_reg;
    case (state_reg)
      charger_pkg::ST_OFF: begin
        if (permit) begin
          state_next = charger_pkg::ST_DISCH;
        end
      end
      charger_pkg::ST_DISCH: begin
        if (sns.below_low_battery) begin
          state_next = charger_pkg::ST_LOWI;
        end else if (disch_done) begin
          state_next = charger_pkg::ST_CHARGE;
        end
      end
      charger_pkg::ST_LOWI: begin
        if (sns.above_recharge) begin
          state_next = charger_pkg::ST_DISCH;
          absent_next = 1'b1;
        end else if (lowi_done) begin
          state_next = charger_pkg::ST_CHARGE;
        end
      end
      charger_pkg::ST_CHARGE: begin
        absent_next = 1'b0;
        if (safety_done) begin
          state_next = sns.above_recharge ? charger_pkg::ST_FAULT_HI :
                                            charger_pkg::ST_FAULT_LO;
        end else if (sns.charge_done) begin
          state_next = charger_pkg::ST_DONE;
        end
      end
      charger_pkg::ST_DONE: begin
        if (~sns.above_recharge) begin
          state_next = charger_pkg::ST_CHARGE;
        end
      end
      charger_pkg::ST_FAULT_HI: begin
        if (~sns.above_recharge) begin
          state_next = charger_pkg::ST_DISCH;
        end
      end
      charger_pkg::ST_FAULT_LO: begin
        if (sns.above_recharge) begin
          state_next = charger_pkg::ST_FAULT_HI;
        end
      end
      default: begin
        state_next = charger_pkg::ST_OFF;
      end
    endcase
    // Permit low inhibits detection and clears any latched fault.
    if (~permit) begin
      state_next = charger_pkg::ST_OFF;
      absent_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= charger_pkg::ST_OFF;
      absent_reg <= 1'b0;
      permit_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      absent_reg <= absent_next;
      permit_d_reg <= permit;
    end
  end

  // Detection window restarts on every change of state.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || permit_fall || state_next != state_reg) begin
      win_reg <= '0;
    end else if (ms_tick) begin
      win_reg <= win_reg + 1'b1;
    end
  end

  // Safety timer only advances while fast charge is really running.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || permit_fall || safety_clr) begin
      safety_reg <= '0;
    end else if (ms_tick && charging) begin
      safety_reg <= safety_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bootstrap refresh and gate drive.
  // ---------------------------------------------------------------
  logic [SW_W-1:0] sw_cnt_reg;
  logic [2:0] boot_cnt_reg;
  logic [RF_W-1:0] rf_cnt_reg;
  logic cyc_end;
  logic refresh_start;
  logic refreshing;
  logic ls_window;
  logic converter_on;

  assign cyc_end = at_last(32'(sw_cnt_reg), SW_CYCLES);
  assign refreshing = (rf_cnt_reg != '0);
  assign refresh_start = cyc_end & sns.bootstrap_low & ~refreshing &
    (boot_cnt_reg >= 3'(charger_pkg::BOOT_LOW_CYCLES));
  assign ls_window =
    (rf_cnt_reg > RF_W'(charger_pkg::DEAD_CYCLES)) &&
    (rf_cnt_reg <= RF_W'(charger_pkg::DEAD_CYCLES +
                         charger_pkg::REFRESH_CYCLES));
  assign converter_on = charging |
    ((state_reg == charger_pkg::ST_LOWI) & supply_valid);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sw_cnt_reg <= '0;
      boot_cnt_reg <= 3'h0;
      rf_cnt_reg <= '0;
    end else begin
      sw_cnt_reg <= cyc_end ? '0 : sw_cnt_reg + 1'b1;
      if (refresh_start) begin
        rf_cnt_reg <= RF_W'(RF_TOTAL);
      end else if (refreshing) begin
        rf_cnt_reg <= rf_cnt_reg - 1'b1;
      end
      // Count consecutive low cycles; a refresh rearms detection.
      if (refresh_start || refreshing) begin
        boot_cnt_reg <= 3'h0;
      end else if (cyc_end) begin
        if (!sns.bootstrap_low) begin
          boot_cnt_reg <= 3'h0;
        end else if (boot_cnt_reg != 3'h7) begin
          boot_cnt_reg <= boot_cnt_reg + 3'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs.
  // ---------------------------------------------------------------
  logic hs_reg;
  logic ls_reg;
  logic disch_reg;
  logic lowi_reg;
  logic trickle_reg;
  logic chg_reg;
  logic pg_reg;
  logic stat_reg;
  logic blink_cond;
  logic stat_next;

  assign blink_cond =
    ((state_reg == charger_pkg::ST_CHARGE) & sns.suspend) |
    (state_reg == charger_pkg::ST_FAULT_HI) |
    (state_reg == charger_pkg::ST_FAULT_LO) |
    sns.input_overvoltage | absent_reg;
  assign stat_next = sns.sleep ? 1'b0 :
                     blink_cond ? blink_ph_reg :
                     charging;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
      disch_reg <= 1'b0;
      lowi_reg <= 1'b0;
      trickle_reg <= 1'b0;
      chg_reg <= 1'b0;
      pg_reg <= 1'b0;
      stat_reg <= 1'b0;
    end else begin
      // Upper switch follows the loop at full duty except in refresh.
      hs_reg <= converter_on & sns.pwm_request & ~refreshing;
      ls_reg <= ls_window;
      disch_reg <= (state_reg == charger_pkg::ST_DISCH);
      lowi_reg <= (state_reg == charger_pkg::ST_LOWI);
      trickle_reg <= (state_reg == charger_pkg::ST_FAULT_LO) &
                     ~sns.above_recharge;
      chg_reg <= charging;
      pg_reg <= supply_valid;
      stat_reg <= stat_next;
    end
  end

  assign hs_gate_o = hs_reg;
  assign ls_gate_o = ls_reg;
  assign discharge_sink_o = disch_reg;
  assign low_current_o = lowi_reg;
  assign fault_trickle_current_o = trickle_reg;
  assign charge_enable_o = chg_reg;
  assign supply_valid_indicator_o = 1'b0;
  assign supply_valid_indicator_oe_o = pg_reg;
  assign charge_state_indicator_o = 1'b0;
  assign charge_state_indicator_oe_o = stat_reg;

  // Status word seen by software.
  assign status.state = state_reg;
  assign status.charging = charging;
  assign status.timer_fault = (state_reg == charger_pkg::ST_FAULT_HI) |
                              (state_reg == charger_pkg::ST_FAULT_LO);
  assign status.battery_absent = absent_reg;
  assign status.supply_valid = supply_valid;
  assign status.stat_pin_level = pin_bits[0];
  assign status.pg_pin_level = pin_bits[1];
  assign status.refresh_active = refreshing;

endmodule

// ---- charger_ctrl_monitor.sv ----
// Port-level checks of the charger control, bound to every instance.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/100ps
module charger_ctrl_monitor (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire charger_pkg::sense_t sense_i,
  input wire logic hs_gate_o,
  input wire logic ls_gate_o,
  input wire logic discharge_sink_o,
  input wire logic low_current_o,
  input wire logic fault_trickle_current_o,
  input wire logic charge_enable_o,
  input wire logic supply_valid_indicator_oe_o,
  input wire logic charge_state_indicator_oe_o
);
  logic [5:0] ls_run_reg;
  wire logic supply_ok = !sense_i.undervoltage_lockout &&
    !sense_i.input_overvoltage && !sense_i.sleep;
  wire logic any_drive = charge_enable_o || discharge_sink_o ||
    low_current_o || fault_trickle_current_o;
  wire logic [3:0] mode = {discharge_sink_o, low_current_o,
    charge_enable_o, fault_trickle_current_o};

  // Counts how long the present refresh pulse has lasted.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !ls_gate_o) begin
      ls_run_reg <= 6'h00;
    end else begin
      ls_run_reg <= ls_run_reg + 6'h01;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_pg_on;
    supply_ok [*6] |-> supply_valid_indicator_oe_o;
  endproperty
  a_pg_on: assert property (p_pg_on) else $error("pg not on");
  property p_pg_off;
    !supply_ok [*6] |-> !supply_valid_indicator_oe_o;
  endproperty
  a_pg_off: assert property (p_pg_off) else $error("pg not off");
  property p_permit_low;
    !sense_i.charge_permit [*6] |-> !any_drive;
  endproperty
  a_permit_low: assert property (p_permit_low)
    else $error("drive with permit low");
  property p_sleep_stat;
    sense_i.sleep [*6] |-> !charge_state_indicator_oe_o;
  endproperty
  a_sleep_stat: assert property (p_sleep_stat)
    else $error("stat on in sleep");
  property p_trickle_above;
    sense_i.above_recharge [*6] |-> !fault_trickle_current_o;
  endproperty
  a_trickle_above: assert property (p_trickle_above)
    else $error("trickle above recharge");
  property p_gate_excl;
    !(hs_gate_o && ls_gate_o);
  endproperty
  a_gate_excl: assert property (p_gate_excl)
    else $error("both gates on");
  property p_ls_len;
    $fell(ls_gate_o) |-> ls_run_reg == charger_pkg::REFRESH_CYCLES;
  endproperty
  a_ls_len: assert property (p_ls_len) else $error("refresh length");
  property p_dead_after;
    $fell(ls_gate_o) |-> !hs_gate_o [*5];
  endproperty
  a_dead_after: assert property (p_dead_after)
    else $error("no dead time");
  property p_one_mode;
    $onehot0(mode);
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("two modes");
  property p_lowi_entry;
    $rose(low_current_o) |-> $past(discharge_sink_o);
  endproperty
  a_lowi_entry: assert property (p_lowi_entry)
    else $error("low current not after sink");
endmodule

bind charger_ctrl charger_ctrl_monitor charger_ctrl_monitor_i (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .sense_i(sense_i),
  .hs_gate_o(hs_gate_o), .ls_gate_o(ls_gate_o),
  .discharge_sink_o(discharge_sink_o), .low_current_o(low_current_o),
  .fault_trickle_current_o(fault_trickle_current_o),
  .charge_enable_o(charge_enable_o),
  .supply_valid_indicator_oe_o(supply_valid_indicator_oe_o),
  .charge_state_indicator_oe_o(charge_state_indicator_oe_o));

// ---- battery_stage_model.sv ----
// Behavioural battery node and bootstrap capacitor beside the charger.
// Assumes the charger outputs change on the same core clock.
`timescale 1ns/100ps
module battery_stage_model #(
  parameter int unsigned LEAK_CYCLES = 20
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic absent_i,
  input wire logic above_i,
  input wire logic below_i,
  input wire logic discharge_sink_i,
  input wire logic low_current_i,
  input wire logic hs_gate_i,
  input wire logic ls_gate_i,
  output logic above_recharge_o,
  output logic below_low_battery_o,
  output logic bootstrap_low_o
);
  logic [3:0] node_reg;
  logic [5:0] boot_reg;
  // An empty socket leaves only the output capacitor: the sink drains it
  // and the low current refills it within a few cycles.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      node_reg <= 4'h8;
    end else if (discharge_sink_i && node_reg != 4'h0) begin
      node_reg <= node_reg - 4'h1;
    end else if (low_current_i && node_reg != 4'hF) begin
      node_reg <= node_reg + 4'h1;
    end
  end
  // The bootstrap capacitor leaks while the upper switch is on.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || ls_gate_i) begin
      boot_reg <= 6'h00;
    end else if (hs_gate_i && boot_reg != 6'h3F) begin
      boot_reg <= boot_reg + 6'h01;
    end
  end
  assign above_recharge_o = absent_i ? (node_reg > 4'hB) : above_i;
  assign below_low_battery_o = absent_i ? (node_reg < 4'h4) : below_i;
  assign bootstrap_low_o = {26'h0, boot_reg} >= LEAK_CYCLES;
endmodule

// ---- charger_ctrl_tb.sv ----
// Self-checking bench for the charger control block.
// Assumes the package, the model and the checker are compiled first.
`timescale 1ns/100ps
module charger_ctrl_tb;
  localparam int HS = 7, LS = 6, SNK = 5, LOWC = 4, TRK = 3, CHG = 2;
  localparam int PG = 1, STAT = 0;
  logic core_clk = 1'b0;
  logic srst, hsel, hwrite, hrdy, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, st;
  charger_pkg::sense_t drv, sense;
  logic absent, above, below, above_w, below_w, boot_w;
  logic hs, ls, snk, lowc, trk, chg, pg_d, pg_oe, st_d, st_oe;
  int bad_count = 0, num_checks = 0;
  logic [3:0] rows [8] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};
  wire logic [7:0] obs = {hs, ls, snk, lowc, trk, chg, pg_oe, st_oe};
  // Both lamps hang on pull-ups, so a released pin reads high.
  wire logic pg_pin = pg_oe ? pg_d : 1'b1;
  wire logic st_pin = st_oe ? st_d : 1'b1;

  always_comb begin
    sense = drv;
    sense.above_recharge = above_w;
    sense.below_low_battery = below_w;
    sense.bootstrap_low = boot_w;
  end

  charger_ctrl #(.MS_CYCLES(10), .DISCH_MS(4), .LOWI_MS(4), .BLINK_MS(2),
    .SAFETY_MS(80), .SW_CYCLES(40)) charger_ctrl_i (
    .core_clk_i(core_clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .sense_i(sense),
    .hs_gate_o(hs), .ls_gate_o(ls), .discharge_sink_o(snk),
    .low_current_o(lowc), .fault_trickle_current_o(trk),
    .charge_enable_o(chg), .supply_valid_indicator_i(pg_pin),
    .supply_valid_indicator_o(pg_d), .supply_valid_indicator_oe_o(pg_oe),
    .charge_state_indicator_i(st_pin), .charge_state_indicator_o(st_d),
    .charge_state_indicator_oe_o(st_oe));

  battery_stage_model battery_stage_model_i (
    .core_clk_i(core_clk), .srst_i(srst), .absent_i(absent),
    .above_i(above), .below_i(below), .discharge_sink_i(snk),
    .low_current_i(lowc), .hs_gate_i(hs), .ls_gate_i(ls),
    .above_recharge_o(above_w), .below_low_battery_o(below_w),
    .bootstrap_low_o(boot_w));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for one output to take a level.
  task automatic wait_for(input int idx, input logic v, input int n);
    int k = 0;
    while (obs[idx] !== v && k < n) begin
      @(posedge core_clk);
      k++;
    end
    chk({31'h0, obs[idx]}, {31'h0, v});
    if (obs[idx] !== v) begin
      final_report();
    end
  endtask

  task automatic edge_rdy();
    int k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hrdy !== 1'b1 && k < 20);
    if (hrdy !== 1'b1) begin
      chk({31'h0, hrdy}, 32'h1);
      final_report();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= charger_pkg::HTRANS_NONSEQ;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    st = hrdata;
  endtask

  task automatic chk_state(input charger_pkg::charge_state_t s);
    bus(1'b0, charger_pkg::STATUS_OFS, 32'h0);
    chk({29'h0, st[2:0]}, {29'h0, s});
  endtask

  initial forever #2.5 core_clk = ~core_clk;

  initial begin
    srst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
    drv = 11'h001;
    {absent, above, below} = 3'h0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk({22'h0, pg_d, st_d, obs}, 32'h0);
    chk({30'h0, hrdy, hresp}, 32'h2);
    bus(1'b0, charger_pkg::CTRL_OFS, 32'h0);
    chk(st, 32'h1);
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk(st, 32'h0);
    for (int i = 0; i < 8; i++) begin
      drv[9:7] <= rows[i][3:1];
      wait_for(PG, rows[i][0], 10);
      bus(1'b0, charger_pkg::STATUS_OFS, 32'h0);
      chk({31'h0, st[6]}, {31'h0, rows[i][0]});
    end
    drv[9:7] <= 3'h0;
    absent <= 1'b1;
    drv.charge_permit <= 1'b1;
    wait_for(SNK, 1'b1, 10);
    wait_for(LOWC, 1'b1, 60);
    wait_for(SNK, 1'b1, 60);
    bus(1'b0, charger_pkg::STATUS_OFS, 32'h0);
    chk({31'h0, st[5]}, 32'h1);
    wait_for(STAT, 1'b1, 60);
    wait_for(STAT, 1'b0, 60);
    drv.charge_permit <= 1'b0;
    repeat (8) @(posedge core_clk);
    bus(1'b0, charger_pkg::STATUS_OFS, 32'h0);
    chk(st, 32'h0000_00C4);
    absent <= 1'b0;
    drv.charge_permit <= 1'b1;
    wait_for(SNK, 1'b1, 10);
    wait_for(CHG, 1'b1, 60);
    chk_state(charger_pkg::ST_CHARGE);
    chk({31'h0, st[3]}, 32'h1);
    wait_for(STAT, 1'b1, 10);
    drv.pwm_request <= 1'b1;
    wait_for(HS, 1'b1, 10);
    wait_for(LS, 1'b1, 300);
    wait_for(LS, 1'b0, 30);
    wait_for(HS, 1'b1, 40);
    wait_for(LS, 1'b1, 300);
    drv.pwm_request <= 1'b0;
    bus(1'b1, charger_pkg::CTRL_OFS, 32'h0);
    wait_for(CHG, 1'b0, 8);
    bus(1'b1, charger_pkg::CTRL_OFS, 32'h1);
    wait_for(CHG, 1'b1, 8);
    drv.suspend <= 1'b1;
    wait_for(STAT, 1'b0, 30);
    wait_for(STAT, 1'b1, 30);
    drv.suspend <= 1'b0;
    wait_for(CHG, 1'b1, 8);
    {above, drv.charge_done} <= 2'b11;
    wait_for(CHG, 1'b0, 8);
    wait_for(STAT, 1'b0, 8);
    chk_state(charger_pkg::ST_DONE);
    {above, drv.charge_done} <= 2'b00;
    wait_for(CHG, 1'b1, 8);
    drv.sleep <= 1'b1;
    wait_for(STAT, 1'b0, 8);
    drv.sleep <= 1'b0;
    wait_for(TRK, 1'b1, 900);
    chk_state(charger_pkg::ST_FAULT_LO);
    chk({31'h0, st[4]}, 32'h1);
    above <= 1'b1;
    wait_for(TRK, 1'b0, 8);
    repeat (20) @(posedge core_clk);
    chk_state(charger_pkg::ST_FAULT_HI);
    above <= 1'b0;
    wait_for(SNK, 1'b1, 8);
    below <= 1'b1;
    wait_for(LOWC, 1'b1, 40);
    below <= 1'b0;
    wait_for(CHG, 1'b1, 60);
    wait_for(TRK, 1'b1, 900);
    drv.charge_permit <= 1'b0;
    wait_for(TRK, 1'b0, 8);
    chk_state(charger_pkg::ST_OFF);
    chk({31'h0, st[4]}, 32'h0);
    final_report();
  end
endmodule
